// File: src/tenmeg_pkg.sv
// Constants shared by the line driver test and self-test extension logic
package tenmeg_pkg;
	// ----------------------------------------
	// Register map (printed offset is an index)
	// ----------------------------------------
	localparam logic [7:0] LDT_REG_INDEX = 8'h1B;
	localparam logic [7:0] LDT_REG_ADDR = 8'(LDT_REG_INDEX * 4);
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int TALLY_LSB = 8;
	localparam int CONT_BIT = 5;
	localparam int PAT_ON_BIT = 4;
	localparam int GAP_BIT = 2;
	localparam int CHOICE_LSB = 0;
	localparam logic [7:0] CTRL_WR_MASK = 8'hFF;
	localparam logic [7:0] TALLY_MAX = 8'hFF;

	// ----------------------------------------
	// Pattern choice codes
	// ----------------------------------------
	localparam logic [1:0] PAT_DATA_A = 2'h0;
	localparam logic [1:0] PAT_DATA_B = 2'h1;
	localparam logic [1:0] PAT_LINK_PULSE = 2'h2;
	localparam logic [1:0] PAT_TONE = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int CLK_NS = 4;
	localparam int BIT_NS = 100;
	localparam int BIT_CYC = BIT_NS / CLK_NS;
	localparam int GAP_SHORT_US = 10;
	localparam int GAP_LONG_US = 15;
	localparam logic [11:0] GAP_SHORT_CYC = 12'(GAP_SHORT_US * CLK_MHZ);
	localparam logic [11:0] GAP_LONG_CYC = 12'(GAP_LONG_US * CLK_MHZ);

	// ----------------------------------------
	// Sequence lengths in bit times, and the data LFSR seed
	// ----------------------------------------
	localparam logic [6:0] DATA_BITS = 7'h40;
	localparam logic [6:0] EOP_A_BITS = 7'h03;
	localparam logic [6:0] EOP_B_BITS = 7'h02;
	localparam logic [6:0] LFSR_SEED = 7'h5A;
endpackage : tenmeg_pkg

// File: src/sat_tally.sv
// Saturating eight-bit tally of errored nibbles
`timescale 1ns/1ps
module sat_tally
	import tenmeg_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic clear,
	input wire logic bump,
	// Count
	output logic [7:0] tally
);
	typedef struct packed {
		logic [7:0] cnt;
	} tally_t;

	tally_t s_r;
	tally_t s_nxt;

	// An error in the restart cycle still counts
	always_comb begin
		s_nxt = s_r;
		if (clear) begin
			s_nxt.cnt = bump ? 8'h01 : 8'h00;
		end else if (bump && s_r.cnt != TALLY_MAX) begin
			s_nxt.cnt = s_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tally = s_r.cnt;
endmodule : sat_tally

// File: src/interval_timer.sv
// One-shot down counter that pulses when a loaded interval ends
`timescale 1ns/1ps
module interval_timer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	input wire logic [11:0] load,
	// Status
	output logic done,
	output logic busy
);
	typedef struct packed {
		logic [11:0] cnt;
		logic busy;
		logic done;
	} timer_t;

	timer_t s_r;
	timer_t s_nxt;

	// Done rises exactly load cycles after the start edge
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (start) begin
			s_nxt.cnt = load;
			s_nxt.busy = 1'b1;
		end else if (s_r.busy) begin
			s_nxt.cnt = s_r.cnt - 12'h001;
			if (s_r.cnt == 12'h001) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;
	assign busy = s_r.busy;
endmodule : interval_timer

// File: src/tenmeg_test_pattern_bist_ext.sv
// Line driver test patterns and packet self-test extensions behind an APB register
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module tenmeg_test_pattern_bist_ext
	import tenmeg_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Packet self-test and receive checker
	input wire logic bist_active,
	input wire logic rx_nibble_err,
	output logic selftest_nonstop_tx,
	// Jabber interlock
	input wire logic tenbase_t_mode,
	input wire logic jabber_guard_off,
	output logic jabber_on,
	// Line driver unit test stream, one bit per strobe
	output logic drv_test_active,
	output logic drv_bit,
	output logic drv_bit_stb,
	output logic drv_eop_a,
	output logic drv_eop_b,
	output logic drv_nlp
);
	typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_EOP, ST_NLP, ST_GAP, ST_TONE} seq_state_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		seq_state_t st;
		logic [6:0] lfsr;
		logic [6:0] cnt;
		logic [4:0] bit_div;
		logic gap_long;
		logic eop_b_sel;
		logic bist_prev;
		logic nonstop;
		logic jab_on;
		logic drv_active;
		logic drv_bit;
		logic drv_stb;
		logic eop_a;
		logic eop_b;
		logic nlp;
	} core_t;

	core_t s_r;
	core_t s_nxt;
	logic [7:0] tally;
	logic gap_done;
	logic gap_start;
	logic bit_tick;
	logic restart;
	logic wr_hit;
	logic pat_on;
	logic [1:0] choice;

	// ----------------------------------------
	// Control field views
	// ----------------------------------------
	assign pat_on = s_r.ctrl[PAT_ON_BIT];
	assign choice = s_r.ctrl[CHOICE_LSB +: 2];
	assign bit_tick = (s_r.bit_div == 5'h00);
	assign restart = bist_active && !s_r.bist_prev;
	assign wr_hit = psel && penable && s_r.pready && pwrite && (paddr == LDT_REG_ADDR);

	// ----------------------------------------
	// Errored nibble tally
	// ----------------------------------------
	sat_tally u_tally (
		.pclk(pclk),
		.presetn(presetn),
		.clear(restart),
		.bump(bist_active && rx_nibble_err),
		.tally(tally)
	);

	// ----------------------------------------
	// Inter-sequence gap timer
	// ----------------------------------------
	interval_timer u_gap (
		.pclk(pclk),
		.presetn(presetn),
		.start(gap_start),
		.load(s_r.ctrl[GAP_BIT] ? GAP_LONG_CYC : GAP_SHORT_CYC),
		.done(gap_done),
		.busy()
	);

	// Gap starts as the last bit of a data or link pulse sequence ends
	assign gap_start = bit_tick && (((s_r.st == ST_EOP) && (s_r.cnt == 7'h00)) || (s_r.st == ST_NLP));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.bist_prev = bist_active;
		s_nxt.drv_stb = 1'b0;
		// Bit-rate divider: one strobe per 100 ns bit time
		s_nxt.bit_div = bit_tick ? 5'(BIT_CYC - 1) : s_r.bit_div - 5'h01;

		// APB: answer in setup, so the access phase always completes in one cycle
		s_nxt.pready = psel && !penable;
		if (psel && !penable) begin
			if (paddr == LDT_REG_ADDR) begin
				s_nxt.prdata = {16'h0000, tally, s_r.ctrl};
				s_nxt.pslverr = 1'b0;
			end else begin
				s_nxt.prdata = 32'h0000_0000;
				s_nxt.pslverr = 1'b1;
			end
		end
		// Reserved bits are stored as written; software keeps them zero
		if (wr_hit && pstrb[0]) begin
			s_nxt.ctrl = pwdata[7:0] & CTRL_WR_MASK;
		end

		// Continuous mode rides on the running packet self-test
		s_nxt.nonstop = s_r.ctrl[CONT_BIT] && bist_active;
		s_nxt.jab_on = tenbase_t_mode && !jabber_guard_off;

		// Pattern sequencer, advanced on bit strobes except in the gap, which ends on gap_done
		case (s_r.st)
			ST_IDLE: begin
				// Hold the test path between sequences so the driver never slips back mid-pattern
				s_nxt.drv_active = s_r.drv_active && pat_on;
				s_nxt.drv_bit = 1'b0;
				if (pat_on && bit_tick) begin
					s_nxt.drv_active = 1'b1;
					s_nxt.gap_long = s_r.ctrl[GAP_BIT];
					if (choice == PAT_DATA_A || choice == PAT_DATA_B) begin
						s_nxt.st = ST_DATA;
						s_nxt.cnt = DATA_BITS - 7'h01;
						s_nxt.eop_b_sel = (choice == PAT_DATA_B);
						s_nxt.lfsr = LFSR_SEED;
					end else if (choice == PAT_LINK_PULSE) begin
						s_nxt.st = ST_NLP;
					end else begin
						s_nxt.st = ST_TONE;
					end
				end
			end
			ST_DATA: begin
				if (bit_tick) begin
					s_nxt.drv_bit = s_r.lfsr[6];
					s_nxt.drv_stb = 1'b1;
					s_nxt.lfsr = {s_r.lfsr[5:0], s_r.lfsr[6] ^ s_r.lfsr[5]};
					s_nxt.cnt = s_r.cnt - 7'h01;
					if (s_r.cnt == 7'h00) begin
						s_nxt.st = ST_EOP;
						s_nxt.cnt = (s_r.eop_b_sel ? EOP_B_BITS : EOP_A_BITS) - 7'h01;
					end
				end
			end
			ST_EOP: begin
				if (bit_tick) begin
					s_nxt.drv_bit = 1'b1;
					s_nxt.drv_stb = 1'b1;
					s_nxt.eop_a = !s_r.eop_b_sel;
					s_nxt.eop_b = s_r.eop_b_sel;
					s_nxt.cnt = s_r.cnt - 7'h01;
					if (s_r.cnt == 7'h00) begin
						s_nxt.st = ST_GAP;
					end
				end
			end
			ST_NLP: begin
				if (bit_tick) begin
					s_nxt.drv_bit = 1'b1;
					s_nxt.drv_stb = 1'b1;
					s_nxt.nlp = 1'b1;
					s_nxt.st = ST_GAP;
				end
			end
			ST_GAP: begin
				s_nxt.drv_bit = 1'b0;
				s_nxt.eop_a = 1'b0;
				s_nxt.eop_b = 1'b0;
				s_nxt.nlp = 1'b0;
				// Gap end is the sequence boundary where disable takes hold
				if (gap_done) begin
					s_nxt.st = ST_IDLE;
					s_nxt.drv_active = pat_on;
				end
			end
			ST_TONE: begin
				// Every bit a one; the driver's encoder makes the 10 MHz tone
				if (bit_tick) begin
					if (pat_on) begin
						s_nxt.drv_bit = 1'b1;
						s_nxt.drv_stb = 1'b1;
					end else begin
						s_nxt.st = ST_IDLE;
						s_nxt.drv_active = 1'b0;
						s_nxt.drv_bit = 1'b0;
					end
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.ctrl <= CTRL_RESET;
			s_r.st <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign selftest_nonstop_tx = s_r.nonstop;
	assign jabber_on = s_r.jab_on;
	assign drv_test_active = s_r.drv_active;
	assign drv_bit = s_r.drv_bit;
	assign drv_bit_stb = s_r.drv_stb;
	assign drv_eop_a = s_r.eop_a;
	assign drv_eop_b = s_r.eop_b;
	assign drv_nlp = s_r.nlp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Helper: cycles spent in the gap, read only by a check
	logic [11:0] gap_cyc_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cyc_r <= 12'h000;
		end else begin
			gap_cyc_r <= (s_r.st == ST_GAP) ? gap_cyc_r + 12'h001 : 12'h000;
		end
	end

	sequence seq_err_at_max;
		bist_active && rx_nibble_err && !restart && tally == TALLY_MAX;
	endsequence

	sequence seq_gap_end;
		s_r.st == ST_GAP && gap_done;
	endsequence

	chk_tally_count: assert property (@(posedge pclk) disable iff (!presetn)
		bist_active && rx_nibble_err && !restart && tally != TALLY_MAX |=> tally == $past(tally) + 8'h01)
		else $error("tally did not count an errored nibble");
	chk_tally_clear: assert property (@(posedge pclk) disable iff (!presetn)
		restart && !rx_nibble_err |=> tally == 8'h00)
		else $error("tally not cleared on self-test restart");
	chk_tally_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		seq_err_at_max |=> tally == TALLY_MAX)
		else $error("tally wrapped past its maximum");
	chk_nonstop_gate: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.ctrl[CONT_BIT] && bist_active |=> selftest_nonstop_tx ##1
		(selftest_nonstop_tx || !$past(bist_active) || !$past(s_r.ctrl[CONT_BIT])))
		else $error("continuous mode not driven with self-test running");
	chk_nonstop_off: assert property (@(posedge pclk) disable iff (!presetn)
		!bist_active |=> !selftest_nonstop_tx)
		else $error("continuous mode active without self-test");
	chk_jabber_mode: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(tenbase_t_mode) |=> jabber_on == ($past(tenbase_t_mode) && !$past(jabber_guard_off)))
		else $error("jabber state does not follow mode and disable");
	chk_pattern_idle: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.st == ST_IDLE && !pat_on |=> !drv_test_active && !drv_bit_stb)
		else $error("test pattern started while disabled");
	chk_gap_length: assert property (@(posedge pclk) disable iff (!presetn)
		seq_gap_end |-> gap_cyc_r == (s_r.gap_long ? GAP_LONG_CYC : GAP_SHORT_CYC))
		else $error("gap length wrong");
	chk_choice_data: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.st == ST_IDLE && pat_on && bit_tick && !choice[1] |=> s_r.st == ST_DATA ##[24:26] drv_bit_stb)
		else $error("data sequence not started for data codes");
	chk_choice_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.st == ST_IDLE && pat_on && bit_tick && choice == PAT_LINK_PULSE |=> ##25 drv_nlp && drv_bit)
		else $error("link pulse not emitted");
	chk_stop_boundary: assert property (@(posedge pclk) disable iff (!presetn)
		seq_gap_end and !pat_on |=> s_r.st == ST_IDLE && !drv_test_active)
		else $error("pattern did not stop at the sequence boundary");
	chk_active_holds: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.st == ST_IDLE && pat_on && drv_test_active |=> drv_test_active)
		else $error("test path dropped between sequences");
	chk_tone_ones: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.st == ST_TONE && drv_bit_stb |-> drv_bit)
		else $error("tone bit was not a one");
	chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("APB access not answered in one cycle");
endmodule : tenmeg_test_pattern_bist_ext

// File: tb/line_partner.sv
// Far-side line observer that tallies the driver test stream
`timescale 1ns/1ps
module line_partner (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic clr,
	// Driver stream
	input wire logic drv_bit,
	input wire logic drv_bit_stb,
	input wire logic drv_eop_a,
	input wire logic drv_eop_b,
	input wire logic drv_nlp,
	// Tallies
	output int n_stb,
	output int n_one,
	output int n_a,
	output int n_b,
	output int n_nlp,
	output int gap_cyc
);
	int since;

	// Count bits per kind; the line only sees a bit when it is strobed
	always @(posedge pclk or negedge presetn) begin
		if (!presetn || clr) begin
			n_stb <= 0;
			n_one <= 0;
			n_a <= 0;
			n_b <= 0;
			n_nlp <= 0;
			gap_cyc <= 0;
			since <= 0;
		end else if (drv_bit_stb) begin
			n_stb <= n_stb + 1;
			n_one <= n_one + int'(drv_bit === 1'b1);
			n_a <= n_a + int'(drv_eop_a === 1'b1);
			n_b <= n_b + int'(drv_eop_b === 1'b1);
			n_nlp <= n_nlp + int'(drv_nlp === 1'b1);
			gap_cyc <= since + 1;
			since <= 0;
		end else begin
			since <= since + 1;
		end
	end
endmodule : line_partner

// File: tb/tenmeg_test_pattern_bist_ext_tb.sv
// Self-checking bench for the line driver test and self-test extension block
`timescale 1ns/1ps
module tenmeg_test_pattern_bist_ext_tb;
	import tenmeg_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, er, bist_active = 0, rx_nibble_err = 0;
	logic tenbase_t_mode = 0, jabber_guard_off = 0, clr = 0;
	logic selftest_nonstop_tx, jabber_on, drv_test_active, drv_bit, drv_bit_stb;
	logic drv_eop_a, drv_eop_b, drv_nlp;
	int n_stb, n_one, n_a, n_b, n_nlp, gap_cyc, err_count = 0, n_tests = 0, cyc = 0;

	tenmeg_test_pattern_bist_ext u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bist_active(bist_active),
		.rx_nibble_err(rx_nibble_err), .selftest_nonstop_tx(selftest_nonstop_tx),
		.tenbase_t_mode(tenbase_t_mode), .jabber_guard_off(jabber_guard_off), .jabber_on(jabber_on),
		.drv_test_active(drv_test_active), .drv_bit(drv_bit), .drv_bit_stb(drv_bit_stb),
		.drv_eop_a(drv_eop_a), .drv_eop_b(drv_eop_b), .drv_nlp(drv_nlp));
	line_partner u_line (.pclk(pclk), .presetn(presetn), .clr(clr), .drv_bit(drv_bit),
		.drv_bit_stb(drv_bit_stb), .drv_eop_a(drv_eop_a), .drv_eop_b(drv_eop_b), .drv_nlp(drv_nlp),
		.n_stb(n_stb), .n_one(n_one), .n_a(n_a), .n_b(n_b), .n_nlp(n_nlp), .gap_cyc(gap_cyc));

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	initial begin
		forever #2 pclk = ~pclk;
	end
	// Ceiling sits well above the roughly 22k cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_count++;
			results();
		end
	end
	task automatic results();
		$display("checks=%0d mismatches=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			err_count++;
		end
	endtask : chk
	// APB master; the leading edge keeps two transfers from touching psel in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// No limit of its own: pready ends this wait, or else the bench timeout
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// Back-to-back error pulses, one per cycle
	task automatic errs(input int n);
		repeat (n) @(posedge pclk) rx_nibble_err <= 1;
		@(posedge pclk) rx_nibble_err <= 0;
	endtask : errs
	task automatic wait_off(input int lim);
		int k;
		for (k = 0; k < lim && drv_test_active !== 1'b0; k++) @(posedge pclk);
		chk(drv_test_active, 1'b0);
	endtask : wait_off

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h0);
		apb(1, LDT_REG_ADDR, 32'h0000FF27);
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h00000027);
		pstrb <= 4'h0;
		apb(1, LDT_REG_ADDR, 32'h00000001);
		pstrb <= 4'hF;
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h00000027);
		apb(0, 8'h70, 0);
		chk({rd[30:0], er}, 32'h1);
		apb(1, LDT_REG_ADDR, 0);
		apb(1, 8'h70, 32'h13);
		chk({31'h0, er}, 32'h1);
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_tally();
		bist_active <= 1;
		errs(5);
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h00000500);
		bist_active <= 0;
		errs(3);
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h00000500);
		bist_active <= 1;
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h0);
		errs(300);
		apb(0, LDT_REG_ADDR, 0);
		chk(rd, 32'h0000FF00);
		$display("test tally done");
	endtask : t_tally
	task automatic t_cont();
		jabber_guard_off <= 1;
		apb(1, LDT_REG_ADDR, 32'h20);
		repeat (2) @(posedge pclk);
		chk(selftest_nonstop_tx, 1'b1);
		bist_active <= 0;
		repeat (3) @(posedge pclk);
		chk(selftest_nonstop_tx, 1'b0);
		apb(1, LDT_REG_ADDR, 0);
		for (int m = 0; m < 4; m++) begin
			@(posedge pclk) {tenbase_t_mode, jabber_guard_off} <= m[1:0];
			repeat (2) @(posedge pclk);
			chk(jabber_on, m == 2);
		end
		$display("test cont done");
	endtask : t_cont
	task automatic t_data(input logic [1:0] c);
		@(posedge pclk) clr <= 1;
		@(posedge pclk) clr <= 0;
		apb(1, LDT_REG_ADDR, {27'h0, 1'b1, 2'b00, c});
		repeat (1800) @(posedge pclk);
		chk(n_stb, c[0] ? 66 : 67);
		chk({n_a[15:0], n_b[15:0]}, c[0] ? 32'h2 : 32'h30000);
		apb(1, LDT_REG_ADDR, {30'h0, c});
		wait_off(4000);
		$display("test data done");
	endtask : t_data
	task automatic t_nlp(input logic g);
		int k, lim;
		lim = g ? int'(GAP_LONG_CYC) : int'(GAP_SHORT_CYC);
		@(posedge pclk) clr <= 1;
		@(posedge pclk) clr <= 0;
		apb(1, LDT_REG_ADDR, {27'h0, 1'b1, 1'b0, g, 2'b10});
		for (k = 0; k < 6000 && n_nlp < 2; k++) @(posedge pclk);
		chk(gap_cyc > lim && gap_cyc <= lim + 60, 1'b1);
		chk({n_stb[15:0], n_one[15:0]}, 32'h20002);
		apb(1, LDT_REG_ADDR, 0);
		wait_off(4000);
		$display("test nlp done");
	endtask : t_nlp
	task automatic t_tone();
		@(posedge pclk) clr <= 1;
		@(posedge pclk) clr <= 0;
		apb(1, LDT_REG_ADDR, 32'h13);
		repeat (300) @(posedge pclk);
		chk(n_stb > 8 && n_one == n_stb, 1'b1);
		chk(gap_cyc, BIT_CYC);
		apb(1, LDT_REG_ADDR, 0);
		wait_off(40);
		$display("test tone done");
	endtask : t_tone

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_tally();
		t_cont();
		t_data(PAT_DATA_A);
		t_data(PAT_DATA_B);
		t_nlp(1'b0);
		t_nlp(1'b1);
		t_tone();
		results();
	end
endmodule : tenmeg_test_pattern_bist_ext_tb
